// *** verilog/stem_matrix_switch_control.sv ***
/*
  Control logic of the 24-track stem monitoring matrix: key handling, track
  source and routing state, mutes, solo, module routing and two presets.
  Assumes keys are raw active-high switches and an AXI4-Lite master.
*/
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module stem_matrix_switch_control #(
  parameter int DEBOUNCE_CYCLES = stem_pkg::DEBOUNCE_CYCLES,
  parameter int HOLD_CYCLES     = stem_pkg::HOLD_CYCLES
) (
  // Clock and reset
  input  wire logic                                         clk_in,
  input  wire logic                                         reset_in,
  // Track keys
  input  wire logic [stem_pkg::NUM_TRACKS-1:0]              cycle_key_in,
  input  wire logic [stem_pkg::NUM_TRACKS-1:0]              solo_key_in,
  input  wire logic [stem_pkg::NUM_TRACKS-1:0]              mute_key_in,
  // Group keys
  input  wire logic [stem_pkg::NUM_GROUPS-1:0]              master_source_key_in,
  input  wire logic [stem_pkg::NUM_GROUPS-1:0]              master_mute_key_in,
  input  wire logic [stem_pkg::NUM_GROUPS-1:0]              trim_key_in,
  // Module keys
  input  wire logic                                         main_to_monitor_key_in,
  input  wire logic                                         mix_to_bus_key_in,
  input  wire logic                                         surround_sum_key_in,
  input  wire logic                                         setup_key_in,
  input  wire logic [stem_pkg::NUM_PRESETS-1:0]             preset_key_in,
  // Track controls and indicators
  output logic      [stem_pkg::NUM_TRACKS-1:0]              track_playback_out,
  output logic      [stem_pkg::NUM_TRACKS-1:0]              track_silence_out,
  output logic      [stem_pkg::NUM_TRACKS-1:0]              track_solo_out,
  output logic      [stem_pkg::NUM_TRACKS*stem_pkg::NUM_OUTPUTS-1:0] track_route_out,
  output logic      [stem_pkg::NUM_TRACKS-1:0]              cycle_led_out,
  output logic      [stem_pkg::NUM_TRACKS-1:0]              red_led_out,
  output logic      [stem_pkg::NUM_TRACKS-1:0]              green_led_out,
  // Group controls
  output logic      [stem_pkg::NUM_GROUPS-1:0]              master_source_out,
  output logic      [stem_pkg::NUM_GROUPS-1:0]              master_mute_out,
  output logic      [stem_pkg::NUM_GROUPS-1:0]              trim_enable_out,
  // Module controls
  output logic                                              control_room_outputs_out,
  output logic                                              mix_to_bus_out,
  output logic                                              surround_sum_out,
  output logic                                              setup_mode_out,
  output logic      [stem_pkg::NUM_PRESETS-1:0]             preset_led_out,
  // AXI4-Lite write address and data
  input  wire logic                                         axi_awvalid_in,
  output logic                                              axi_awready_out,
  input  wire logic [stem_pkg::ADDR_W-1:0]                  axi_awaddr_in,
  input  wire logic                                         axi_wvalid_in,
  output logic                                              axi_wready_out,
  input  wire logic [31:0]                                  axi_wdata_in,
  input  wire logic [3:0]                                   axi_wstrb_in,
  // AXI4-Lite write response
  output logic                                              axi_bvalid_out,
  input  wire logic                                         axi_bready_in,
  output logic      [1:0]                                   axi_bresp_out,
  // AXI4-Lite read
  input  wire logic                                         axi_arvalid_in,
  output logic                                              axi_arready_out,
  input  wire logic [stem_pkg::ADDR_W-1:0]                  axi_araddr_in,
  output logic                                              axi_rvalid_out,
  input  wire logic                                         axi_rready_in,
  output logic      [31:0]                                  axi_rdata_out,
  output logic      [1:0]                                   axi_rresp_out
);
  localparam int NT     = stem_pkg::NUM_TRACKS;
  localparam int NG     = stem_pkg::NUM_GROUPS;
  localparam int NO     = stem_pkg::NUM_OUTPUTS;
  localparam int NP     = stem_pkg::NUM_PRESETS;
  localparam int TPG    = stem_pkg::TRACKS_PER_GROUP;
  localparam int HOLD_W = $clog2(HOLD_CYCLES + 1);
  localparam int IDX_W  = $clog2(NT);

  // Next source mode in key order
  function automatic stem_pkg::src_mode_e step_mode(input stem_pkg::src_mode_e m);
    unique case (m)
      stem_pkg::MODE_DIRECT:   step_mode = stem_pkg::MODE_PLAYBACK;
      stem_pkg::MODE_PLAYBACK: step_mode = stem_pkg::MODE_FOLLOW;
      stem_pkg::MODE_FOLLOW:   step_mode = stem_pkg::MODE_DIRECT;
      default:                 step_mode = stem_pkg::MODE_DIRECT;
    endcase
  endfunction

  // Next routing choice, wrapping through unrouted
  function automatic stem_pkg::route_t step_route(input stem_pkg::route_t r);
    step_route = (r >= stem_pkg::ROUTE_LAST) ? stem_pkg::ROUTE_NONE : r + 1'b1;
  endfunction

  // Effective input selection for a track
  function automatic logic pick_playback(input stem_pkg::src_mode_e m, input logic grp_src);
    pick_playback = (m == stem_pkg::MODE_PLAYBACK) || ((m == stem_pkg::MODE_FOLLOW) && grp_src);
  endfunction

  // Working state
  stem_pkg::src_mode_e mode       [NT];
  stem_pkg::route_t    route      [NT];
  logic [NT-1:0]       mute;
  logic [NT-1:0]       solo;
  logic [NG-1:0]       grp_src;
  logic [NG-1:0]       grp_mute;
  logic [NG-1:0]       grp_trim;
  logic                main_to_monitor;
  logic                mix_to_bus;
  logic                surround_sum;
  logic                setup_mode;
  logic                preset_sel;
  stem_pkg::entry_s    preset_mem [NP][NT];
  logic [HOLD_W-1:0]   hold_cnt   [NP];
  logic [IDX_W-1:0]    track_index;

  // Debounced keys
  logic [stem_pkg::KEY_COUNT-1:0] key_level;
  logic [stem_pkg::KEY_COUNT-1:0] key_press;
  logic [stem_pkg::KEY_COUNT-1:0] key_release;

  key_debounce #(
    .WIDTH  (stem_pkg::KEY_COUNT),
    .CYCLES (DEBOUNCE_CYCLES)
  ) u_keys (
    .clk_in      (clk_in),
    .reset_in    (reset_in),
    .raw_in      ({preset_key_in, setup_key_in, surround_sum_key_in, mix_to_bus_key_in,
                   main_to_monitor_key_in, trim_key_in, master_mute_key_in,
                   master_source_key_in, mute_key_in, solo_key_in, cycle_key_in}),
    .level_out   (key_level),
    .press_out   (key_press),
    .release_out (key_release)
  );

  // Key event slices
  wire [NT-1:0] cyc_ev   = key_press[stem_pkg::KEY_CYCLE +: NT];
  wire [NT-1:0] solo_ev  = key_press[stem_pkg::KEY_SOLO +: NT];
  wire [NT-1:0] mute_ev  = key_press[stem_pkg::KEY_MUTE +: NT];
  wire [NG-1:0] gsrc_ev  = key_press[stem_pkg::KEY_GSRC +: NG];
  wire [NG-1:0] gmute_ev = key_press[stem_pkg::KEY_GMUTE +: NG];
  wire [NG-1:0] gtrim_ev = key_press[stem_pkg::KEY_GTRIM +: NG];
  wire [NP-1:0] pre_lvl  = key_level[stem_pkg::KEY_PRESET +: NP];
  wire [NP-1:0] pre_rel  = key_release[stem_pkg::KEY_PRESET +: NP];

  // Preset store on long hold, recall on short release
  logic [NP-1:0] store_req;
  logic [NP-1:0] recall_req;
  for (genvar k = 0; k < NP; k++) begin : g_hold
    assign store_req[k]  = pre_lvl[k] && (hold_cnt[k] == HOLD_W'(HOLD_CYCLES - 1));
    assign recall_req[k] = pre_rel[k] && (hold_cnt[k] < HOLD_W'(HOLD_CYCLES));
  end
  wire do_store  = |store_req;
  wire do_recall = |recall_req;
  wire slot_sel  = do_store ? !store_req[0] : !recall_req[0];

  // Hold time measured per preset key
  always_ff @(posedge clk_in) begin
    for (int k = 0; k < NP; k++) begin
      if (reset_in || !pre_lvl[k]) begin
        hold_cnt[k] <= '0;
      end else if (hold_cnt[k] != HOLD_W'(HOLD_CYCLES)) begin
        hold_cnt[k] <= hold_cnt[k] + 1'b1;
      end
    end
  end

  // Preset slots hold mode, routing and mute of every track
  always_ff @(posedge clk_in) begin
    for (int k = 0; k < NP; k++) begin
      for (int i = 0; i < NT; i++) begin
        if (reset_in) begin
          preset_mem[k][i] <= '{mute: 1'b0, mode: stem_pkg::MODE_DIRECT, route: stem_pkg::ROUTE_NONE};
        end else if (do_store && (slot_sel == k[0])) begin
          preset_mem[k][i] <= '{mute: mute[i], mode: mode[i], route: route[i]};
        end
      end
    end
  end

  // Per-track mode, routing, mute and solo
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < NT; i++) begin
      if (reset_in) begin
        mode[i]  <= stem_pkg::MODE_DIRECT;
        route[i] <= stem_pkg::ROUTE_NONE;
        mute[i]  <= 1'b0;
        solo[i]  <= 1'b0;
      end else if (do_recall) begin
        mode[i]  <= preset_mem[slot_sel][i].mode;
        route[i] <= preset_mem[slot_sel][i].route;
        mute[i]  <= preset_mem[slot_sel][i].mute;
      end else begin
        if (cyc_ev[i] && setup_mode) begin
          route[i] <= step_route(route[i]);
        end else if (cyc_ev[i]) begin
          mode[i] <= step_mode(mode[i]);
        end
        if (mute_ev[i]) begin
          mute[i] <= !mute[i];
        end
        if (solo_ev[i]) begin
          solo[i] <= !solo[i];
        end
      end
    end
  end

  // Group master keys toggle on each press
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      grp_src  <= '0;
      grp_mute <= '0;
      grp_trim <= '0;
    end else begin
      grp_src  <= grp_src ^ gsrc_ev;
      grp_mute <= grp_mute ^ gmute_ev;
      grp_trim <= grp_trim ^ gtrim_ev;
    end
  end

  // AXI write channel state
  logic                       aw_held;
  logic                       w_held;
  logic [stem_pkg::ADDR_W-1:0] aw_addr;
  logic [31:0]                w_data;
  logic                       w_lane0;
  wire aw_take  = axi_awvalid_in && axi_awready_out;
  wire w_take   = axi_wvalid_in && axi_wready_out;
  wire wr_go    = aw_held && w_held && !axi_bvalid_out;
  wire wr_ctrl  = wr_go && w_lane0 && (aw_addr == stem_pkg::ADDR_CTRL);
  wire wr_index = wr_go && w_lane0 && (aw_addr == stem_pkg::ADDR_INDEX);
  wire wr_known = (aw_addr == stem_pkg::ADDR_CTRL) || (aw_addr == stem_pkg::ADDR_INDEX) ||
                  (aw_addr == stem_pkg::ADDR_TRACK) || (aw_addr == stem_pkg::ADDR_GROUP) ||
                  (aw_addr == stem_pkg::ADDR_PRESET);
  wire [IDX_W-1:0] wr_idx = w_data[IDX_W-1:0];

  assign axi_awready_out = !aw_held && !axi_bvalid_out;
  assign axi_wready_out  = !w_held && !axi_bvalid_out;

  // Module-wide switches: keys toggle, software writes set
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      main_to_monitor <= 1'b0;
      mix_to_bus      <= 1'b0;
      surround_sum    <= 1'b0;
      setup_mode      <= 1'b0;
      preset_sel      <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        main_to_monitor <= w_data[stem_pkg::CTRL_MAIN];
        mix_to_bus      <= w_data[stem_pkg::CTRL_MIX];
        surround_sum    <= w_data[stem_pkg::CTRL_SURR];
        setup_mode      <= w_data[stem_pkg::CTRL_SETUP];
      end else begin
        main_to_monitor <= main_to_monitor ^ key_press[stem_pkg::KEY_MAIN];
        mix_to_bus      <= mix_to_bus ^ key_press[stem_pkg::KEY_MIX];
        surround_sum    <= surround_sum ^ key_press[stem_pkg::KEY_SURR];
        setup_mode      <= setup_mode ^ key_press[stem_pkg::KEY_SETUP];
      end
      if (do_store || do_recall) begin
        preset_sel <= slot_sel;
      end
    end
  end

  // Write address, data and response
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      aw_held        <= 1'b0;
      w_held         <= 1'b0;
      aw_addr        <= '0;
      w_data         <= '0;
      w_lane0        <= 1'b0;
      axi_bvalid_out <= 1'b0;
      axi_bresp_out  <= stem_pkg::RESP_OKAY;
      track_index    <= '0;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= axi_awaddr_in;
      end
      if (w_take) begin
        w_held  <= 1'b1;
        w_data  <= axi_wdata_in;
        w_lane0 <= axi_wstrb_in[0];
      end
      if (wr_go) begin
        aw_held        <= 1'b0;
        w_held         <= 1'b0;
        axi_bvalid_out <= 1'b1;
        axi_bresp_out  <= wr_known ? stem_pkg::RESP_OKAY : stem_pkg::RESP_SLVERR;
      end else if (axi_bready_in) begin
        axi_bvalid_out <= 1'b0;
      end
      if (wr_index && (wr_idx < IDX_W'(NT))) begin
        track_index <= wr_idx;
      end
    end
  end

  // Per-track derived controls and indicators
  logic [NT-1:0] playback;
  for (genvar i = 0; i < NT; i++) begin : g_track
    localparam int G = i / TPG;
    assign playback[i]           = pick_playback(mode[i], grp_src[G]);
    assign track_silence_out[i]  = mute[i] || grp_mute[G];
    assign track_solo_out[i]     = solo[i];
    assign cycle_led_out[i]      = (mode[i] != stem_pkg::MODE_FOLLOW);
    assign red_led_out[i]        = !playback[i];
    assign green_led_out[i]      = playback[i];
    for (genvar o = 0; o < NO; o++) begin : g_route
      assign track_route_out[i*NO+o] = (route[i] == stem_pkg::route_t'(o + 1));
    end
  end
  assign track_playback_out = playback;

  // Group and module outputs
  assign master_source_out        = grp_src;
  assign master_mute_out          = grp_mute;
  assign trim_enable_out          = grp_trim;
  assign control_room_outputs_out = main_to_monitor;
  assign mix_to_bus_out           = mix_to_bus;
  assign surround_sum_out         = surround_sum;
  assign setup_mode_out           = setup_mode;
  assign preset_led_out           = {preset_sel, !preset_sel};

  // Read decode
  wire [NT-1:0] sel_bit = NT'(1) << track_index;
  wire          sel_pb  = |(playback & sel_bit);
  wire          sel_mut = |(mute & sel_bit);
  wire          sel_sil = |(track_silence_out & sel_bit);
  wire          sel_sol = |(solo & sel_bit);
  wire [31:0]   rd_ctrl  = 32'({setup_mode, surround_sum, mix_to_bus, main_to_monitor});
  wire [31:0]   rd_index = 32'(track_index);
  wire [31:0]   rd_track = 32'({sel_sil, sel_sol, sel_pb, sel_mut, mode[track_index], route[track_index]});
  wire [31:0]   rd_group = 32'({grp_trim, grp_mute, grp_src});
  wire [31:0]   rd_pre   = 32'({setup_mode, preset_sel});
  wire          rd_ok    = (axi_araddr_in == stem_pkg::ADDR_CTRL) || (axi_araddr_in == stem_pkg::ADDR_INDEX) ||
                           (axi_araddr_in == stem_pkg::ADDR_TRACK) || (axi_araddr_in == stem_pkg::ADDR_GROUP) ||
                           (axi_araddr_in == stem_pkg::ADDR_PRESET);
  wire [31:0]   rd_mux   = (axi_araddr_in == stem_pkg::ADDR_CTRL)  ? rd_ctrl  :
                           (axi_araddr_in == stem_pkg::ADDR_INDEX) ? rd_index :
                           (axi_araddr_in == stem_pkg::ADDR_TRACK) ? rd_track :
                           (axi_araddr_in == stem_pkg::ADDR_GROUP) ? rd_group :
                           (axi_araddr_in == stem_pkg::ADDR_PRESET) ? rd_pre : '0;

  assign axi_arready_out = !axi_rvalid_out;

  // Read answer one cycle after the address is taken
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      axi_rvalid_out <= 1'b0;
      axi_rdata_out  <= '0;
      axi_rresp_out  <= stem_pkg::RESP_OKAY;
    end else if (axi_arvalid_in && axi_arready_out) begin
      axi_rvalid_out <= 1'b1;
      axi_rdata_out  <= rd_mux;
      axi_rresp_out  <= rd_ok ? stem_pkg::RESP_OKAY : stem_pkg::RESP_SLVERR;
    end else if (axi_rready_in) begin
      axi_rvalid_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** verilog/stem_pkg.sv ***
/*
  Constants, types and register map of the stem monitoring matrix control.
  Assumes a 20 MHz system clock and an AXI4-Lite master for software access.
*/
// Summary of operation
// - Twenty-four tracks form four groups of six, each with direct and playback.
// - Each track lights at most one of six routing indicators: L, R, C, SL, SR, sub-bass.
// - Outside setup, cycle key steps direct, playback, follow-master, direct.
// - Direct mode selects direct input, lights cycle LED and red LED.
// - Playback mode selects playback input, lights cycle LED and green LED.
// - Follow mode darkens cycle LED; source and red/green follow master key.
// - Master source key toggles only follow-mode tracks of its group.
// - Solo key puts the selected input, post trim, on the solo bus.
// - Individual mute key silences the track output while active.
// - Group master mute silences all six tracks regardless of own mutes.
// - Releasing master mute restores every previous per-track setting.
// - Trim enable hands group level to the trim pot, else fixed level.
// - Main-to-monitor key connects six main outputs to control room outputs.
// - Mix-to-bus key connects six summed matrix outputs to master buses.
// - Surround-sum key feeds mono surround to both surround outputs.
// - In setup mode each track's cycle key assigns it to an output.
// - A programmed setup is stored into preset slot A or B.
// - Exactly one preset is active and its stored routing applies.
// - Hold over three seconds stores; shorter press recalls the preset.
// - Setup stepping covers six outputs plus an unrouted choice.
`default_nettype none
package stem_pkg;
  localparam int NUM_GROUPS       = 4;
  localparam int TRACKS_PER_GROUP = 6;
  localparam int NUM_TRACKS       = NUM_GROUPS * TRACKS_PER_GROUP;
  localparam int NUM_OUTPUTS      = 6;
  localparam int NUM_PRESETS      = 2;

  // Timing
  localparam longint CLK_HZ          = 20000000;
  localparam longint DEBOUNCE_MS     = 10;
  localparam longint HOLD_MS         = 3000;
  localparam longint MS_PER_S        = 1000;
  localparam int     DEBOUNCE_CYCLES = int'(DEBOUNCE_MS * CLK_HZ / MS_PER_S);
  localparam int     HOLD_CYCLES     = int'(HOLD_MS * CLK_HZ / MS_PER_S);

  // Key vector layout into the debouncer
  localparam int KEY_CYCLE  = 0;
  localparam int KEY_SOLO   = KEY_CYCLE + NUM_TRACKS;
  localparam int KEY_MUTE   = KEY_SOLO + NUM_TRACKS;
  localparam int KEY_GSRC   = KEY_MUTE + NUM_TRACKS;
  localparam int KEY_GMUTE  = KEY_GSRC + NUM_GROUPS;
  localparam int KEY_GTRIM  = KEY_GMUTE + NUM_GROUPS;
  localparam int KEY_MAIN   = KEY_GTRIM + NUM_GROUPS;
  localparam int KEY_MIX    = KEY_MAIN + 1;
  localparam int KEY_SURR   = KEY_MIX + 1;
  localparam int KEY_SETUP  = KEY_SURR + 1;
  localparam int KEY_PRESET = KEY_SETUP + 1;
  localparam int KEY_COUNT  = KEY_PRESET + NUM_PRESETS;

  typedef enum logic [1:0] {MODE_DIRECT, MODE_PLAYBACK, MODE_FOLLOW} src_mode_e;
  typedef logic [2:0] route_t;
  localparam route_t ROUTE_NONE = 3'h0;
  localparam route_t ROUTE_LAST = 3'h6;

  typedef struct packed {
    logic      mute;
    src_mode_e mode;
    route_t    route;
  } entry_s;

  // AXI4-Lite register map
  localparam int         ADDR_W       = 8;
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_INDEX   = 8'h04;
  localparam logic [7:0] ADDR_TRACK   = 8'h08;
  localparam logic [7:0] ADDR_GROUP   = 8'h0c;
  localparam logic [7:0] ADDR_PRESET  = 8'h10;
  localparam int         CTRL_MAIN    = 0;
  localparam int         CTRL_MIX     = 1;
  localparam int         CTRL_SURR    = 2;
  localparam int         CTRL_SETUP   = 3;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
endpackage
`default_nettype wire

// *** verilog/key_debounce.sv ***
/*
  Debouncer for a vector of front-panel keys.
  Assumes raw keys are asynchronous, active high while pressed.
*/
`timescale 1ns/1ns
`default_nettype none
module key_debounce #(
  parameter int WIDTH  = 8,
  parameter int CYCLES = 200000
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  // Raw keys
  input  wire logic [WIDTH-1:0] raw_in,
  // Clean keys
  output logic      [WIDTH-1:0] level_out,
  output logic      [WIDTH-1:0] press_out,
  output logic      [WIDTH-1:0] release_out
);
  localparam int CNT_W = $clog2(CYCLES + 1);

  logic [WIDTH-1:0] sync1;
  logic [WIDTH-1:0] sync2;
  logic [WIDTH-1:0] sync3;
  logic [WIDTH-1:0] agreed;
  logic [WIDTH-1:0] sample;
  logic [CNT_W-1:0] tick_cnt;
  wire              tick = (tick_cnt == CNT_W'(CYCLES - 1));
  wire  [WIDTH-1:0] stable = (sample & agreed) | (level_out & (sample ^ agreed));
  wire  [WIDTH-1:0] next_level = tick ? stable : level_out;

  // Three-stage synchroniser, change taken when stages two and three agree
  always_ff @(posedge clk_in) begin
    sync1 <= raw_in;
    sync2 <= sync1;
    sync3 <= sync2;
  end

  // Level accepted only when equal at two successive ticks
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      agreed      <= '0;
      sample      <= '0;
      tick_cnt    <= '0;
      level_out   <= '0;
      press_out   <= '0;
      release_out <= '0;
    end else begin
      agreed      <= (sync2 & sync3) | (agreed & (sync2 ^ sync3));
      tick_cnt    <= tick ? '0 : tick_cnt + 1'b1;
      if (tick) begin
        sample <= agreed;
      end
      level_out   <= next_level;
      press_out   <= next_level & ~level_out;
      release_out <= ~next_level & level_out;
    end
  end
endmodule
`default_nettype wire

// *** tb/stem_checker.sv ***
/* Checker of matrix outputs and bus handshakes, bound to the top; sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module stem_checker (
  input wire logic         clk_in, reset_in, axi_awvalid_in, axi_awready_out, axi_wvalid_in, axi_wready_out,
  input wire logic         axi_bvalid_out, axi_bready_in, axi_arvalid_in, axi_arready_out, axi_rvalid_out,
  input wire logic [23:0]  track_playback_out, track_silence_out, red_led_out, green_led_out,
  input wire logic [143:0] track_route_out,
  input wire logic [3:0]   master_mute_out,
  input wire logic [1:0]   preset_led_out
);
  logic [23:0] gm_miss, rt_bad;
  // Per-track group mute gaps and multi-output routes
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      gm_miss[i] = master_mute_out[i/6] & ~track_silence_out[i];
      rt_bad[i]  = !$onehot0(track_route_out[6*i +: 6]);
    end
  end
  // Both write channels taken at one edge
  sequence s_wr_taken;
    axi_awvalid_in && axi_awready_out && axi_wvalid_in && axi_wready_out;
  endsequence
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  a_red_led_src: assert property (red_led_out == ~track_playback_out) else $error("red led wrong");
  a_green_led_src: assert property (green_led_out == track_playback_out) else $error("green led wrong");
  a_group_mute_all: assert property (gm_miss == 24'h0) else $error("group mute leak");
  a_route_one_out: assert property (rt_bad == 24'h0) else $error("track on two outputs");
  a_preset_one_hot: assert property ($onehot(preset_led_out)) else $error("preset led not one-hot");
  a_wr_resp_time: assert property (s_wr_taken |-> ##2 axi_bvalid_out) else $error("write response late");
  a_wr_resp_hold: assert property (axi_bvalid_out && !axi_bready_in |=> axi_bvalid_out) else $error("bvalid dropped");
  a_rd_resp_time: assert property (axi_arvalid_in && axi_arready_out |=> axi_rvalid_out) else $error("read data late");
endmodule
bind stem_matrix_switch_control stem_checker u_chk (.clk_in, .reset_in, .axi_awvalid_in, .axi_awready_out,
  .axi_wvalid_in, .axi_wready_out, .axi_bvalid_out, .axi_bready_in, .axi_arvalid_in, .axi_arready_out,
  .axi_rvalid_out, .track_playback_out, .track_silence_out, .red_led_out, .green_led_out, .track_route_out,
  .master_mute_out, .preset_led_out);
`default_nettype wire

// *** tb/key_operator.sv ***
/* Operator model: presses front-panel keys with contact bounce.
   Keys are raw, active high; the clock is the block's own. */
`timescale 1ns/1ns
`default_nettype none
module key_operator (
  input  wire logic                           clk_in,
  output var logic [stem_pkg::KEY_COUNT-1:0] key_out
);
  initial key_out = '0;
  // One bounce, a hold of given length, then a quiet gap
  task automatic press(input int k, input int hold);
    key_out[k] <= 1'b1;
    @(posedge clk_in) key_out[k] <= 1'b0;
    @(posedge clk_in) key_out[k] <= 1'b1;
    repeat (hold) @(posedge clk_in);
    key_out[k] <= 1'b0;
    repeat (40) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
/* Self-checking bench of the matrix control: key sequences and register reads.
   Short debounce and hold counts; operator model drives all keys. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk_in, reset_in, awv, wv, bready, arv, rready, awr, wr_r, bv, arr, rv;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdat, d;
  logic [1:0] bresp, rresp, pled, r;
  logic [23:0] pb, sil, cled, red;
  logic [143:0] route;
  logic [stem_pkg::KEY_COUNT-1:0] k;
  int n_errors = 0, checks = 0;
  key_operator op (.clk_in(clk_in), .key_out(k));
  stem_matrix_switch_control #(.DEBOUNCE_CYCLES(4), .HOLD_CYCLES(50)) DUT (.clk_in(clk_in), .reset_in(reset_in),
    .cycle_key_in(k[stem_pkg::KEY_CYCLE +: 24]), .solo_key_in(k[stem_pkg::KEY_SOLO +: 24]),
    .mute_key_in(k[stem_pkg::KEY_MUTE +: 24]), .master_source_key_in(k[stem_pkg::KEY_GSRC +: 4]),
    .master_mute_key_in(k[stem_pkg::KEY_GMUTE +: 4]), .trim_key_in(k[stem_pkg::KEY_GTRIM +: 4]),
    .main_to_monitor_key_in(k[stem_pkg::KEY_MAIN]), .mix_to_bus_key_in(k[stem_pkg::KEY_MIX]),
    .surround_sum_key_in(k[stem_pkg::KEY_SURR]), .setup_key_in(k[stem_pkg::KEY_SETUP]),
    .preset_key_in(k[stem_pkg::KEY_PRESET +: 2]), .track_playback_out(pb),
    .track_silence_out(sil), .track_solo_out(), .track_route_out(route), .cycle_led_out(cled), .red_led_out(red),
    .green_led_out(), .master_source_out(), .master_mute_out(), .trim_enable_out(), .control_room_outputs_out(),
    .mix_to_bus_out(), .surround_sum_out(), .setup_mode_out(), .preset_led_out(pled), .axi_awvalid_in(awv),
    .axi_awready_out(awr), .axi_awaddr_in(awa), .axi_wvalid_in(wv), .axi_wready_out(wr_r), .axi_wdata_in(wd),
    .axi_wstrb_in(4'hf), .axi_bvalid_out(bv), .axi_bready_in(bready), .axi_bresp_out(bresp), .axi_arvalid_in(arv),
    .axi_arready_out(arr), .axi_araddr_in(ara), .axi_rvalid_out(rv), .axi_rready_in(rready), .axi_rdata_out(rdat),
    .axi_rresp_out(rresp));
  // 20 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Register write: both channels offered, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n = 0;
    awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clk_in); n++;
      if (awr) awv <= 1'b0;
      if (wr_r) wv <= 1'b0;
    end while (!bv && n < 50);
    bready <= 1'b0;
    if (n >= 50) begin n_errors++; conclude(); end
  endtask
  // Register read, data and response taken at the rvalid edge
  task automatic rd(input logic [7:0] a);
    int n = 0;
    ara <= a; arv <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk_in); n++;
      if (arr) arv <= 1'b0;
    end while (!rv && n < 50);
    d = rdat; r = rresp;
    if (n >= 50) begin n_errors++; conclude(); end
  endtask
  initial begin
    reset_in = 1'b1; awv = 0; wv = 0; bready = 0; arv = 0; rready = 0; awa = 0; ara = 0; wd = 0;
    repeat (16) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    chk(pled, 2'h1);
    chk({cled[0], red[0], pb[0]}, 3'h6);
    op.press(stem_pkg::KEY_CYCLE, 30); chk({cled[0], red[0], pb[0]}, 3'h5);
    op.press(stem_pkg::KEY_CYCLE, 30); chk({cled[0], red[0], pb[0]}, 3'h2);
    op.press(stem_pkg::KEY_GSRC, 30); chk({pb[0], pb[1], pb[6]}, 3'h4);
    op.press(stem_pkg::KEY_CYCLE, 30); chk({cled[0], red[0], pb[0]}, 3'h6);
    op.press(stem_pkg::KEY_MUTE, 30); chk(sil[5:0], 6'h01);
    op.press(stem_pkg::KEY_GMUTE, 30); chk({sil[6], sil[5:0]}, 7'h3f);
    op.press(stem_pkg::KEY_GMUTE, 30); chk(sil[5:0], 6'h01);
    op.press(stem_pkg::KEY_PRESET + 1, 90); chk(pled, 2'h2);
    op.press(stem_pkg::KEY_MUTE, 30); op.press(stem_pkg::KEY_PRESET, 30); chk({pled, sil[0]}, 3'h2);
    op.press(stem_pkg::KEY_PRESET + 1, 30); chk({pled, sil[0]}, 3'h5);
    op.press(stem_pkg::KEY_SETUP, 30); op.press(stem_pkg::KEY_SOLO, 30); op.press(stem_pkg::KEY_GTRIM, 30);
    for (int i = 1; i < 8; i++) begin
      op.press(stem_pkg::KEY_CYCLE + 2, 30); chk(route[17:12], (i < 7) ? 6'h1 << (i - 1) : 6'h0);
    end
    wr(stem_pkg::ADDR_CTRL, 32'hf); rd(stem_pkg::ADDR_CTRL); chk({r, d[3:0]}, 6'h0f);
    rd(stem_pkg::ADDR_PRESET); chk({r, d[1:0]}, 4'h3);
    rd(stem_pkg::ADDR_TRACK); chk(d[8:0], 9'h1a0); rd(stem_pkg::ADDR_GROUP); chk(d[11:0], 12'h101);
    rd(8'h14); chk(r, stem_pkg::RESP_SLVERR);
    conclude();
  end
endmodule
`default_nettype wire
